// *** logic/iop_bus.sv ***
`timescale 1ns/1ns
module iop_bus #(
  parameter int QP_CYCLES = 1  // core clocks per quarter-phase
) (
  // clock and reset
  input wire logic core_clk,
  input wire logic reset,
  // core side request
  input wire logic req_valid,
  input wire logic req_write,
  input wire iop_pkg::iop_space_t req_space,
  input wire logic [iop_pkg::ADDR_W-1:0] req_addr,
  input wire logic [iop_pkg::DATA_W-1:0] req_wdata,
  output logic req_ready,
  output logic rsp_valid,
  output logic [iop_pkg::DATA_W-1:0] rsp_rdata,
  // external bus
  output logic [iop_pkg::ADDR_W-1:0] ext_addr,
  input wire logic [iop_pkg::DATA_W-1:0] ext_data_in,
  output logic [iop_pkg::DATA_W-1:0] ext_data_out,
  output logic ext_data_oe,
  output logic ext_rw,
  output logic io_space_strobe_n,
  output logic program_space_strobe_n,
  output logic data_space_strobe_n,
  output logic cycle_begin_strobe_n,
  output logic phase_clock_out,
  input wire logic ext_ready
);
  // ***************************************************************
  // parameter check
  // ***************************************************************
  initial begin
    if (QP_CYCLES < 1 || QP_CYCLES > 255) begin
      $error("QP_CYCLES out of range");
    end
  end

  // ***************************************************************
  // ready input synchroniser
  // ***************************************************************
  logic rdy_s1_ff, rdy_s2_ff, rdy_s3_ff, rdy_ff;
  logic nxt_rdy;
  // filtered level changes only when stages two and three agree
  always_comb begin
    nxt_rdy = rdy_ff;
    if (rdy_s2_ff == rdy_s3_ff) begin
      nxt_rdy = rdy_s3_ff;
    end
  end
  always_ff @(posedge core_clk) begin
    if (reset) begin
      rdy_s1_ff <= 1'b1;
      rdy_s2_ff <= 1'b1;
      rdy_s3_ff <= 1'b1;
      rdy_ff <= 1'b1;
    end else begin
      rdy_s1_ff <= ext_ready;
      rdy_s2_ff <= rdy_s1_ff;
      rdy_s3_ff <= rdy_s2_ff;
      rdy_ff <= nxt_rdy;
    end
  end

  // ***************************************************************
  // quarter-phase timebase, free running
  // ***************************************************************
  logic [7:0] tick_ff, nxt_tick;          // clocks within a quarter
  logic [1:0] qp_ff, nxt_qp;              // current quarter-phase
  logic qp_end;                           // last clock of a quarter
  assign qp_end = (tick_ff == 8'(QP_CYCLES - 1));
  always_comb begin
    nxt_tick = qp_end ? 8'h00 : tick_ff + 8'h01;
    nxt_qp = qp_end ? qp_ff + 2'h1 : qp_ff;
  end
  always_ff @(posedge core_clk) begin
    if (reset) begin
      tick_ff <= 8'h00;
      qp_ff <= iop_pkg::QP_1;
    end else begin
      tick_ff <= nxt_tick;
      qp_ff <= nxt_qp;
    end
  end

  // ***************************************************************
  // bus cycle sequencer
  // ***************************************************************
  iop_pkg::iop_state_t st_ff, nxt_st;
  logic [iop_pkg::ADDR_W-1:0] nxt_addr;
  logic [iop_pkg::DATA_W-1:0] nxt_wdata, nxt_rdata;
  logic nxt_oe, nxt_rw, nxt_is, nxt_ps, nxt_ds, nxt_clk;
  logic nxt_req_ready, nxt_rsp_valid;
  logic go_ff, nxt_go;                    // ready seen high at quarter 3
  logic cyc_start, cyc_done;
  // a new cycle may only start on the quarter 1 boundary
  assign cyc_start = (st_ff == iop_pkg::IOP_ST_IDLE) && req_valid &&
                     qp_end && (qp_ff == iop_pkg::QP_4);
  // cycle ends at the falling edge after ready was high
  assign cyc_done = (st_ff == iop_pkg::IOP_ST_BUSY) && go_ff &&
                    qp_end && (qp_ff == iop_pkg::QP_4);

  always_comb begin
    nxt_st = st_ff;
    nxt_addr = ext_addr;
    nxt_wdata = ext_data_out;
    nxt_rdata = rsp_rdata;
    nxt_oe = ext_data_oe;
    nxt_rw = ext_rw;
    nxt_is = io_space_strobe_n;
    nxt_ps = program_space_strobe_n;
    nxt_ds = data_space_strobe_n;
    nxt_go = go_ff;
    nxt_rsp_valid = 1'b0;
    nxt_req_ready = 1'b0;
    // output clock low in quarters 1-2, high in 3-4, so that a
    // finished cycle ends on the falling edge
    nxt_clk = nxt_qp[1];
    case (st_ff)
      iop_pkg::IOP_ST_IDLE: begin
        if (cyc_start) begin
          nxt_st = iop_pkg::IOP_ST_BUSY;
          nxt_req_ready = 1'b1;
          nxt_go = 1'b0;
          // io space keeps only the port number on low lines
          if (req_space == iop_pkg::IOP_SPACE_IO) begin
            nxt_addr = {{(iop_pkg::ADDR_W-iop_pkg::PORT_W){1'b0}},
                        req_addr[iop_pkg::PORT_W-1:0]};
          end else begin
            nxt_addr = req_addr;
          end
          // one strobe per space, same timing for all
          nxt_is = (req_space != iop_pkg::IOP_SPACE_IO);
          nxt_ps = (req_space != iop_pkg::IOP_SPACE_PROG);
          nxt_ds = (req_space != iop_pkg::IOP_SPACE_DATA);
          nxt_rw = ~req_write;
          // output instruction drives, input instruction reads
          nxt_oe = req_write;
          nxt_wdata = req_wdata;
        end
      end
      iop_pkg::IOP_ST_BUSY: begin
        if (qp_end && qp_ff == iop_pkg::QP_2) begin
          nxt_go = rdy_ff;               // sample at quarter 3
        end
        if (cyc_done) begin
          nxt_st = iop_pkg::IOP_ST_IDLE;
          nxt_rsp_valid = 1'b1;
          if (ext_rw) begin
            nxt_rdata = ext_data_in;
          end
          nxt_is = 1'b1;
          nxt_ps = 1'b1;
          nxt_ds = 1'b1;
          nxt_oe = 1'b0;
          nxt_rw = 1'b1;
        end
        // ready low: strobes, address, data, oe and rw held, phase clock keeps running, next cycle samples again
      end
      default: begin
        nxt_st = iop_pkg::IOP_ST_IDLE;
      end
    endcase
  end

  // begin strobe: low in clock-low half of the first machine cycle
  logic first_ff, nxt_first;
  always_comb begin
    nxt_first = first_ff;
    if (cyc_start) begin
      nxt_first = 1'b1;
    end else if (qp_end && qp_ff == iop_pkg::QP_4) begin
      nxt_first = 1'b0;
    end
  end
  logic msc_q;
  // next value of the flag, so the strobe falls with the space strobe
  assign msc_q = ~(nxt_first && !nxt_qp[1]);

  always_ff @(posedge core_clk) begin
    if (reset) begin
      st_ff <= iop_pkg::IOP_ST_IDLE;
      ext_addr <= iop_pkg::ADDR_RST;
      ext_data_out <= iop_pkg::DATA_RST;
      rsp_rdata <= iop_pkg::DATA_RST;
      ext_data_oe <= 1'b0;
      ext_rw <= 1'b1;
      io_space_strobe_n <= 1'b1;
      program_space_strobe_n <= 1'b1;
      data_space_strobe_n <= 1'b1;
      cycle_begin_strobe_n <= 1'b1;
      phase_clock_out <= 1'b0;
      go_ff <= 1'b0;
      first_ff <= 1'b0;
      req_ready <= 1'b0;
      rsp_valid <= 1'b0;
    end else begin
      st_ff <= nxt_st;
      ext_addr <= nxt_addr;
      ext_data_out <= nxt_wdata;
      rsp_rdata <= nxt_rdata;
      ext_data_oe <= nxt_oe;
      ext_rw <= nxt_rw;
      io_space_strobe_n <= nxt_is;
      program_space_strobe_n <= nxt_ps;
      data_space_strobe_n <= nxt_ds;
      cycle_begin_strobe_n <= msc_q;
      phase_clock_out <= nxt_clk;
      go_ff <= nxt_go;
      first_ff <= nxt_first;
      req_ready <= nxt_req_ready;
      rsp_valid <= nxt_rsp_valid;
    end
  end

  // ***************************************************************
  // checks
  // ***************************************************************
  property p_one_strobe;
    @(posedge core_clk) disable iff (reset)
    (!io_space_strobe_n) |-> (program_space_strobe_n &&
                              data_space_strobe_n);
  endproperty
  a_one_strobe: assert property (p_one_strobe)
    else $error("io strobe overlaps memory strobe");
  property p_io_addr;
    @(posedge core_clk) disable iff (reset)
    (!io_space_strobe_n) |-> (ext_addr[15:4] == 12'h000);
  endproperty
  a_io_addr: assert property (p_io_addr)
    else $error("io address above port field");
  property p_io_start;
    @(posedge core_clk) disable iff (reset)
    (cyc_start && req_space == iop_pkg::IOP_SPACE_IO) |=>
      (!io_space_strobe_n && !phase_clock_out && !cycle_begin_strobe_n);
  endproperty
  a_io_start: assert property (p_io_start)
    else $error("io strobe late at cycle start");
  property p_stretch;
    @(posedge core_clk) disable iff (reset)
    (st_ff == iop_pkg::IOP_ST_BUSY && !go_ff && qp_end &&
     qp_ff == iop_pkg::QP_4) |=> (st_ff == iop_pkg::IOP_ST_BUSY);
  endproperty
  a_stretch: assert property (p_stretch)
    else $error("cycle ended without ready");
  property p_hold;
    @(posedge core_clk) disable iff (reset)
    (st_ff == iop_pkg::IOP_ST_BUSY && !cyc_done) |=>
      $stable(ext_addr);
  endproperty
  a_hold: assert property (p_hold)
    else $error("address moved during cycle");
  property p_oe;
    @(posedge core_clk) disable iff (reset)
    ext_data_oe |-> !ext_rw;
  endproperty
  a_oe: assert property (p_oe)
    else $error("data driven on a read");
  property p_msc;
    @(posedge core_clk) disable iff (reset)
    (!cycle_begin_strobe_n) |-> (!phase_clock_out);
  endproperty
  a_msc: assert property (p_msc)
    else $error("begin strobe while clock high");
  property p_same_timing;
    @(posedge core_clk) disable iff (reset)
    $fell(io_space_strobe_n) |-> (req_ready && $past(ext_rw) &&
                                  (ext_rw == !ext_data_oe));
  endproperty
  a_same_timing: assert property (p_same_timing)
    else $error("io strobe off the common cycle start");
endmodule

// *** pkg/iop_pkg.sv ***
package iop_pkg;
  // ***************************************************************
  // widths and port space geometry
  // ***************************************************************
  localparam int ADDR_W = 16;          // external address bus width
  localparam int DATA_W = 16;          // external data bus width
  localparam int PORT_W = 4;           // port number on low address lines
  localparam int NUM_PORTS = 16;       // ports per direction
  // ***************************************************************
  // quarter-phase sequencing of one machine cycle
  // ***************************************************************
  localparam logic [1:0] QP_1 = 2'h0;  // clock out low, cycle begins
  localparam logic [1:0] QP_2 = 2'h1;  // clock out low
  localparam logic [1:0] QP_3 = 2'h2;  // clock out high, ready sampled
  localparam logic [1:0] QP_4 = 2'h3;  // clock out high, cycle may end
  // ***************************************************************
  // reset values of the bus pins
  // ***************************************************************
  localparam logic [15:0] ADDR_RST = 16'h0000;
  localparam logic [15:0] DATA_RST = 16'h0000;
  // ***************************************************************
  // bus cycle kinds and states
  // ***************************************************************
  typedef enum logic [1:0] {
    IOP_SPACE_PROG = 2'b00,
    IOP_SPACE_DATA = 2'b01,
    IOP_SPACE_IO = 2'b10
  } iop_space_t;
  typedef enum logic [1:0] {
    IOP_ST_IDLE = 2'b00,
    IOP_ST_BUSY = 2'b01
  } iop_state_t;
endpackage

// *** test/iop_periph.sv ***
`timescale 1ns/1ns
// ****
// port-space peripheral: latches, input ports, ready
// ****
module iop_periph #(
  parameter int QP_CYCLES = 4  // core clocks per quarter-phase
) (
  // clock and reset
  input wire logic core_clk,
  input wire logic reset,
  // processor bus
  input wire logic [15:0] ext_addr,
  input wire logic [15:0] ext_data_out,
  input wire logic ext_rw,
  input wire logic io_space_strobe_n,
  input wire logic program_space_strobe_n,
  input wire logic data_space_strobe_n,
  output logic [15:0] ext_data_in,
  output logic ext_ready,
  // bench control and observation
  input wire logic [1:0] wait_sel,
  output logic [15:0] out_port [16],
  output logic [15:0] out_full
);
  logic [15:0] last_ff;  // last bus value, inverted when released
  logic [8:0] wait_ff;  // remaining not-ready clocks
  logic busy_ff;  // a strobe was low last clock
  logic any_sel;
  logic io_sel;
  assign any_sel = !(io_space_strobe_n && program_space_strobe_n &&
                     data_space_strobe_n);
  // decode only the low four lines, only under the io strobe
  assign io_sel = !io_space_strobe_n;
  // released bus toggles so a stale value never looks valid
  assign ext_data_in = (io_sel && ext_rw) ?
    {4'ha, ext_addr[3:0], ~ext_addr[3:0], 4'h5} : ~last_ff;
  assign ext_ready = (wait_ff == 9'h000);
  // capture writes, count wait clocks from strobe fall
  always_ff @(posedge core_clk) begin
    if (reset) begin
      busy_ff <= 1'b0;
      wait_ff <= 9'h000;
      last_ff <= 16'h0000;
      out_full <= 16'h0000;
      for (int i = 0; i < 16; i++) out_port[i] <= 16'h0000;
    end else begin
      last_ff <= ext_data_in;
      busy_ff <= any_sel;
      if (any_sel && !busy_ff) begin
        wait_ff <= 9'(wait_sel * 4 * QP_CYCLES);
      end else if (wait_ff != 9'h000) begin
        wait_ff <= wait_ff - 9'h001;
      end
      if (io_sel && !ext_rw) begin
        out_port[ext_addr[3:0]] <= ext_data_out;
        out_full[ext_addr[3:0]] <= 1'b1;  // data-ready flag
      end
    end
  end
endmodule

// *** test/tb.sv ***
`timescale 1ns/1ns
module tb;
  // ****
  // signals
  // ****
  logic core_clk = 1'b0;
  logic reset = 1'b1;
  logic req_valid = 1'b0;
  logic req_write = 1'b0;
  iop_pkg::iop_space_t req_space = iop_pkg::IOP_SPACE_IO;
  logic [15:0] req_addr = 16'h0000;
  logic [15:0] req_wdata = 16'h0000;
  logic [1:0] wait_sel = 2'h0;
  logic req_ready, rsp_valid, ext_data_oe, ext_rw, ext_ready;
  logic io_n, pr_n, da_n, beg_n, ph_clk;
  logic [15:0] rsp_rdata, ext_addr, ext_data_in, ext_data_out, out_full;
  logic [15:0] out_port [16];
  int num_errors = 0;
  int n_checks = 0;
  int n0;  // zero-wait cycle length
  always #10 core_clk = ~core_clk;
  // long quarters so the ready synchroniser settles before sampling
  iop_bus #(.QP_CYCLES(4)) DUT (.core_clk(core_clk), .reset(reset),
    .req_valid(req_valid), .req_write(req_write), .req_space(req_space),
    .req_addr(req_addr), .req_wdata(req_wdata), .req_ready(req_ready),
    .rsp_valid(rsp_valid), .rsp_rdata(rsp_rdata), .ext_addr(ext_addr),
    .ext_data_in(ext_data_in), .ext_data_out(ext_data_out),
    .ext_data_oe(ext_data_oe), .ext_rw(ext_rw), .io_space_strobe_n(io_n),
    .program_space_strobe_n(pr_n), .data_space_strobe_n(da_n),
    .cycle_begin_strobe_n(beg_n), .phase_clock_out(ph_clk),
    .ext_ready(ext_ready));
  iop_periph #(.QP_CYCLES(4)) peer (.core_clk(core_clk), .reset(reset),
    .ext_addr(ext_addr), .ext_data_out(ext_data_out), .ext_rw(ext_rw),
    .io_space_strobe_n(io_n), .program_space_strobe_n(pr_n),
    .data_space_strobe_n(da_n), .ext_data_in(ext_data_in),
    .ext_ready(ext_ready), .wait_sel(wait_sel), .out_port(out_port),
    .out_full(out_full));
  // ****
  // shared tasks
  // ****
  task automatic report_and_stop();
    if (num_errors == 0 && n_checks > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp) begin
      num_errors++;
      $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic timeout();
    num_errors++;
    report_and_stop();
  endtask
  // one bus cycle; n counts clocks from strobe fall to completion
  task automatic access(input iop_pkg::iop_space_t sp, input logic wr,
      input logic [15:0] a, input int w, output int n);
    logic [2:0] es;
    logic [15:0] ea;
    logic bs;
    logic io;
    io = (sp == iop_pkg::IOP_SPACE_IO);
    es = io ? 3'b011 : (sp == iop_pkg::IOP_SPACE_PROG) ? 3'b101 : 3'b110;
    ea = io ? {12'h000, a[3:0]} : a;
    bs = 1'b0;
    n = 0;
    @(posedge core_clk);
    wait_sel <= w[1:0];
    req_valid <= 1'b1;
    req_write <= wr;
    req_space <= sp;
    req_addr <= a;
    req_wdata <= ~a;
    for (int k = 0; k < 100 && req_ready !== 1'b1; k++) begin
      @(posedge core_clk);
      #1;
    end
    if (req_ready !== 1'b1) timeout();
    if (wr) check(ext_data_out, 16'(~a));
    // space strobes, address, rw and oe hold for the whole cycle, waits included
    while (rsp_valid !== 1'b1 && n < 300) begin
      check({io_n, pr_n, da_n, ext_addr, ext_rw, ext_data_oe},
            {es, ea, !wr, wr});
      if (beg_n === 1'b0) begin
        bs = 1'b1;
        check(ph_clk, 1'b0);
      end
      @(posedge core_clk);
      req_valid <= 1'b0;
      #1;
      n++;
    end
    if (n >= 300) timeout();
    check({bs, io_n & pr_n & da_n}, 2'b11);
    if (io && !wr) begin
      check(rsp_rdata, {4'ha, a[3:0], ~a[3:0], 4'h5});
    end
    if (io && wr) begin
      check({out_full[a[3:0]], out_port[a[3:0]]}, {1'b1, ~a});
    end
  endtask
  // ****
  // scenarios
  // ****
  task automatic t_reset();
    check({io_n, pr_n, da_n, beg_n, ext_data_oe, ext_rw, ph_clk},
          7'h7a);
  endtask
  // all ports both ways, junk on upper lines, back to back
  task automatic t_ports();
    int n;
    for (int p = 0; p < 16; p++) begin
      access(iop_pkg::IOP_SPACE_IO, 1'b1, 16'h7ff0 | 16'(p), 0, n);
      access(iop_pkg::IOP_SPACE_IO, 1'b0, 16'h7ff0 | 16'(p), 0, n);
      check(n, n0);
    end
  endtask
  // memory spaces take the same number of clocks as port space
  task automatic t_spaces();
    int n;
    access(iop_pkg::IOP_SPACE_PROG, 1'b0, 16'h1234, 0, n);
    check(n, n0);
    access(iop_pkg::IOP_SPACE_DATA, 1'b1, 16'h8765, 0, n);
    check(n, n0);
  endtask
  // each not-ready sample stretches by one machine cycle
  task automatic t_waits();
    int n;
    for (int w = 1; w < 3; w++) begin
      access(iop_pkg::IOP_SPACE_IO, 1'b0, 16'h0009, w, n);
      check(n, n0 + 16 * w);
    end
  endtask
  initial begin
    repeat (6) @(posedge core_clk);
    reset <= 1'b0;
    @(posedge core_clk);
    #1;
    t_reset();
    access(iop_pkg::IOP_SPACE_IO, 1'b0, 16'h0003, 0, n0);
    // one machine cycle is four quarters of four clocks
    check(n0, 32'h0000_0010);
    t_ports();
    t_spaces();
    t_waits();
    report_and_stop();
  end
endmodule
